// [design/pin_mux_pkg.sv]
`default_nettype none

package pin_mux_pkg;

	// ==================================================================
	// configuration bit location and array shape
	// manual frequency control bit address inside the device map
	localparam logic [7:0]  MANUAL_BIT_ADDR = 8'h04;
	localparam int          NUM_PLL        = 3;
	localparam int          NUM_SLOT       = 4;

	// ==================================================================
	// per-slot configuration word layout
	localparam int          PRE_W          = 8;
	localparam int          N_W            = 12;
	localparam int          A_W            = 4;
	localparam int          OFS_W          = 6;
	localparam int          FILT_W         = 4;
	localparam int          PUMP_W         = 3;
	localparam int          PRE_LSB        = 0;
	localparam int          N_LSB          = 8;
	localparam int          A_LSB          = 20;
	localparam int          OFS_LSB        = 24;
	localparam int          FRAC_LSB       = 30;
	localparam int          RES_LSB        = 31;
	localparam int          CAPA_LSB       = 35;
	localparam int          CAPB_LSB       = 39;
	localparam int          PUMP_LSB       = 43;
	localparam int          ODIV_LSB       = 46;
	localparam int          CFG_W          = 47;
	localparam logic [46:0] CFG_RESET      = 47'h0000_0000_0000;

	// ==================================================================
	// scan shift word: config word, then pll index, then slot index
	localparam int          SCAN_PLL_LSB   = 47;
	localparam int          SCAN_SLOT_LSB  = 49;
	localparam int          SCAN_W         = 51;

	// ==================================================================
	// derived quantities
	localparam int          UA_W           = 10;
	localparam logic [9:0]  PUMP_BASE_UA   = 10'h005;
	localparam int          FRAC_SHIFT     = 6;
	localparam int          MULT_INT_W     = 14;
	localparam int          MULT_W         = 20;

	typedef enum logic [1:0] {
		mode_single_pll,
		mode_all_pll,
		mode_serial,
		mode_test
	} mode_e;

	typedef enum logic [1:0] {
		tap_reset,
		tap_idle,
		tap_shift,
		tap_update
	} tap_state_e;

endpackage : pin_mux_pkg

`default_nettype wire

// [design/multipurpose_pin_mode_mux.sv]
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - mode from control bit and select pin
// - input zero is bus data or scan data
// - input one is bus clock; scan logic runs on link_clock
// - input two steers scan state machine
// - input three high suspends all outputs, except in all-pll mode
// - input four low resets scan logic asynchronously, in scan mode only
// - input five picks primary or secondary reference, except in all-pll mode
// - output zero is scan data or lock loss
// - output one flags lost selected reference
// - four divider slots, two post-divider choices
// - four loop-filter sets per PLL
// - input levels pick each PLL slot
// - multiplier is 2N+A+1 plus offset/64
// - resistor, two capacitor, pump current fields
// - pump current is five microamps times 2^n
// - floating select pin: bit picks single/all
// - select pin high gives serial mode
// - select pin low gives scan mode
module multipurpose_pin_mode_mux (
	// clocks and reset
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic                       link_clock,
	// mode selection
	input  wire logic                       manual_freq_ctrl_bit,
	input  wire logic                       iface_sel_high,
	input  wire logic                       iface_sel_low,
	// multi-purpose input pins
	input  wire logic                       gen_input_zero,
	input  wire logic                       gen_input_one,
	input  wire logic                       gen_input_two,
	input  wire logic                       gen_input_three,
	input  wire logic                       gen_input_four,
	input  wire logic                       gen_input_five,
	// analog status
	input  wire logic                       pll_lock_lost,
	input  wire logic                       ref_clock_lost,
	// slot write port from serial engine
	input  wire logic                       cfg_wr_en,
	input  wire logic [1:0]                 cfg_wr_pll,
	input  wire logic [1:0]                 cfg_wr_slot,
	input  wire logic [46:0]                cfg_wr_data,
	// multi-purpose output pins
	output var  logic                       gen_output_zero,
	output var  logic                       gen_output_one,
	// mode and routed functions
	output var  logic [1:0]                 mode_out,
	output var  logic                       serial_mode_active,
	output var  logic                       serial_data_to_engine,
	output var  logic                       serial_clock_to_engine,
	output var  logic                       suspend_outputs,
	output var  logic                       ref_select_secondary,
	// configuration selects
	output var  logic [2:0]                 pll0_cfg_sel,
	output var  logic [1:0]                 pll1_cfg_sel,
	output var  logic [1:0]                 pll2_cfg_sel,
	// selected configuration per pll, pll0 in the low slice
	output var  logic [23:0]                pll_pre_scale,
	output var  logic [35:0]                pll_feedback_count,
	output var  logic [11:0]                pll_additive_count,
	output var  logic [59:0]                pll_total_mult_x64,
	output var  logic [11:0]                filter_resistor_code,
	output var  logic [11:0]                filter_cap_code_a,
	output var  logic [11:0]                filter_cap_code_b,
	output var  logic [8:0]                 pump_current_code,
	output var  logic [29:0]                pump_current_ua,
	output var  logic [2:0]                 post_div_select
);

	// ==================================================================
	// input synchronisers
	logic [9:0]                 pin_raw;
	logic [9:0]                 sync1_ff;
	logic [9:0]                 sync2_ff;
	logic                       ref_missing_flag;
	logic                       lock_lost_s;

	assign pin_raw = {ref_clock_lost, pll_lock_lost, iface_sel_low, iface_sel_high,
		gen_input_five, gen_input_four, gen_input_three, gen_input_two,
		gen_input_one, gen_input_zero};

	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_sync
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sync1_ff[g] <= 1'b0;
					sync2_ff[g] <= 1'b0;
				end else begin
					sync1_ff[g] <= pin_raw[g];
					sync2_ff[g] <= sync1_ff[g];
				end
			end
		end
	endgenerate

	assign lock_lost_s      = sync2_ff[8];
	assign ref_missing_flag = sync2_ff[9];

	// ==================================================================
	// mode decode and configuration selects
	pin_mux_pkg::mode_e         mode_ff;
	pin_mux_pkg::mode_e         nxt_mode;
	logic [2:0]                 sel0_ff;
	logic [2:0]                 nxt_sel0;
	logic [1:0]                 sel1_ff;
	logic [1:0]                 nxt_sel1;
	logic [1:0]                 sel2_ff;
	logic [1:0]                 nxt_sel2;

	always_comb begin
		// a pin driven both ways reads as high; pad compare makes it rare
		if (sync2_ff[6]) begin
			nxt_mode = pin_mux_pkg::mode_serial;
		end else if (sync2_ff[7]) begin
			nxt_mode = pin_mux_pkg::mode_test;
		end else if (manual_freq_ctrl_bit) begin
			nxt_mode = pin_mux_pkg::mode_single_pll;
		end else begin
			nxt_mode = pin_mux_pkg::mode_all_pll;
		end
		nxt_sel0 = sel0_ff;
		nxt_sel1 = sel1_ff;
		nxt_sel2 = sel2_ff;
		// programming modes keep the last selection so slots do not jump
		case (nxt_mode)
			pin_mux_pkg::mode_single_pll: begin
				nxt_sel0 = sync2_ff[2:0];
				nxt_sel1 = 2'h0;
				nxt_sel2 = 2'h0;
			end
			pin_mux_pkg::mode_all_pll: begin
				nxt_sel0 = {1'b0, sync2_ff[1:0]};
				nxt_sel1 = sync2_ff[3:2];
				nxt_sel2 = sync2_ff[5:4];
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= pin_mux_pkg::mode_all_pll;
			sel0_ff <= 3'h0;
			sel1_ff <= 2'h0;
			sel2_ff <= 2'h0;
		end else begin
			mode_ff <= nxt_mode;
			sel0_ff <= nxt_sel0;
			sel1_ff <= nxt_sel1;
			sel2_ff <= nxt_sel2;
		end
	end

	// ==================================================================
	// pin routing
	logic                       test_mode;
	logic                       serial_mode;
	logic                       scan_tdo_ff;

	assign test_mode    = (mode_ff == pin_mux_pkg::mode_test);
	assign serial_mode  = (mode_ff == pin_mux_pkg::mode_serial);
	assign mode_out     = mode_ff;
	assign pll0_cfg_sel = sel0_ff;
	assign pll1_cfg_sel = sel1_ff;
	assign pll2_cfg_sel = sel2_ff;
	assign serial_mode_active     = serial_mode;
	assign serial_data_to_engine  = serial_mode & sync2_ff[0];
	assign serial_clock_to_engine = serial_mode & sync2_ff[1];
	// input three is a slot select in all-pll mode, never a suspend there
	assign suspend_outputs = (mode_ff != pin_mux_pkg::mode_all_pll) & sync2_ff[3];
	assign ref_select_secondary = (mode_ff != pin_mux_pkg::mode_all_pll) & sync2_ff[5];
	assign gen_output_zero = test_mode ? scan_tdo_ff : lock_lost_s;
	assign gen_output_one  = ref_missing_flag;

	// ==================================================================
	// scan port on the link clock
	pin_mux_pkg::tap_state_e    tap_ff;
	pin_mux_pkg::tap_state_e    nxt_tap;
	logic [50:0]                scan_shift_ff;
	logic [50:0]                nxt_scan_shift;
	logic [50:0]                scan_hold_ff;
	logic [50:0]                nxt_scan_hold;
	logic                       scan_tgl_ff;
	logic                       nxt_scan_tgl;
	logic                       nxt_scan_tdo;
	logic                       scan_rst_n;

	// pin four low clears the scan side at once, only while in scan mode
	assign scan_rst_n = rst_n & ~(test_mode & ~gen_input_four);

	always_comb begin
		nxt_tap        = tap_ff;
		nxt_scan_shift = scan_shift_ff;
		nxt_scan_hold  = scan_hold_ff;
		nxt_scan_tgl   = scan_tgl_ff;
		nxt_scan_tdo   = scan_tdo_ff;
		case (tap_ff)
			pin_mux_pkg::tap_reset: begin
				if (!gen_input_two) nxt_tap = pin_mux_pkg::tap_idle;
			end
			pin_mux_pkg::tap_idle: begin
				if (gen_input_two) nxt_tap = pin_mux_pkg::tap_shift;
			end
			pin_mux_pkg::tap_shift: begin
				nxt_scan_shift = {gen_input_zero, scan_shift_ff[50:1]};
				nxt_scan_tdo   = scan_shift_ff[0];
				if (gen_input_two) nxt_tap = pin_mux_pkg::tap_update;
			end
			default: begin
				nxt_scan_hold = scan_shift_ff;
				nxt_scan_tgl  = ~scan_tgl_ff;
				nxt_tap       = pin_mux_pkg::tap_idle;
			end
		endcase
	end

	always_ff @(posedge link_clock or negedge scan_rst_n) begin
		if (!scan_rst_n) begin
			tap_ff        <= pin_mux_pkg::tap_reset;
			scan_shift_ff <= 51'h0_0000_0000_0000;
			scan_tdo_ff   <= 1'b0;
		end else begin
			tap_ff        <= nxt_tap;
			scan_shift_ff <= nxt_scan_shift;
			scan_tdo_ff   <= nxt_scan_tdo;
		end
	end

	// scan reset leaves the crossing alone, else a false update edge
	always_ff @(posedge link_clock or negedge rst_n) begin
		if (!rst_n) begin
			scan_hold_ff <= 51'h0_0000_0000_0000;
			scan_tgl_ff  <= 1'b0;
		end else begin
			scan_hold_ff <= nxt_scan_hold;
			scan_tgl_ff  <= nxt_scan_tgl;
		end
	end

	// ==================================================================
	// update event crossing: toggle, two flops, then edge detect
	// hold word is stable for many link cycles after the toggle moves
	logic                       upd_s1_ff;
	logic                       upd_s2_ff;
	logic                       upd_seen_ff;
	logic                       scan_write;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			upd_s1_ff   <= 1'b0;
			upd_s2_ff   <= 1'b0;
			upd_seen_ff <= 1'b0;
		end else begin
			upd_s1_ff   <= scan_tgl_ff;
			upd_s2_ff   <= upd_s1_ff;
			upd_seen_ff <= upd_s2_ff;
		end
	end

	assign scan_write = test_mode & (upd_s2_ff ^ upd_seen_ff);

	// ==================================================================
	// configuration slots, twelve words
	logic [46:0]                cfg_mem_ff  [12];
	logic [46:0]                nxt_cfg_mem [12];
	logic [3:0]                 wr_index;

	localparam int SCAN_PLL_IDX  = pin_mux_pkg::SCAN_PLL_LSB;
	localparam int SCAN_SLOT_IDX = pin_mux_pkg::SCAN_SLOT_LSB;

	always_comb begin
		for (int i = 0; i < 12; i++) begin
			nxt_cfg_mem[i] = cfg_mem_ff[i];
		end
		wr_index = 4'h0;
		if (scan_write) begin
			wr_index = {scan_hold_ff[SCAN_PLL_IDX+:2], scan_hold_ff[SCAN_SLOT_IDX+:2]};
			if (wr_index < 4'hc) nxt_cfg_mem[wr_index] = scan_hold_ff[46:0];
		end else if (serial_mode && cfg_wr_en) begin
			wr_index = {cfg_wr_pll, cfg_wr_slot};
			if (wr_index < 4'hc) nxt_cfg_mem[wr_index] = cfg_wr_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 12; i++) cfg_mem_ff[i] <= pin_mux_pkg::CFG_RESET;
		end else begin
			for (int i = 0; i < 12; i++) cfg_mem_ff[i] <= nxt_cfg_mem[i];
		end
	end

	// ==================================================================
	// per-pll selected configuration, registered outputs
	generate
		for (g = 0; g < 3; g++) begin : g_pll
			logic [3:0]             rd_index;
			logic [46:0]            word;
			logic [46:0]            sel_cfg_ff;
			logic [9:0]             ua_ff;
			logic [9:0]             nxt_ua;
			logic [19:0]            mult_ff;
			logic [19:0]            nxt_mult;
			logic [13:0]            mult_int;

			localparam int N_L = pin_mux_pkg::N_LSB;
			localparam int A_L = pin_mux_pkg::A_LSB;
			localparam int O_L = pin_mux_pkg::OFS_LSB;
			localparam int I_L = pin_mux_pkg::PUMP_LSB;

			always_comb begin
				rd_index = 4'h0;
				if (g == 0) begin
					// single-pll mode borrows slots two and three of the others
					if (sel0_ff[2]) begin
						rd_index = {sel0_ff[1] ? 2'h2 : 2'h1, 1'b1, sel0_ff[0]};
					end else begin
						rd_index = {2'h0, sel0_ff[1:0]};
					end
				end else if (g == 1) begin
					rd_index = {2'h1, sel1_ff};
				end else begin
					rd_index = {2'h2, sel2_ff};
				end
				word     = cfg_mem_ff[rd_index];
				mult_int = 14'({1'b0, word[N_L+:12], 1'b0}) + 14'(word[A_L+:4]) + 14'h0001;
				nxt_mult = {mult_int, 6'h00};
				if (word[pin_mux_pkg::FRAC_LSB]) begin
					nxt_mult = nxt_mult + 20'(word[O_L+:6]);
				end
				nxt_ua = 10'(pin_mux_pkg::PUMP_BASE_UA << word[I_L+:3]);
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sel_cfg_ff <= pin_mux_pkg::CFG_RESET;
					ua_ff      <= 10'h000;
					mult_ff    <= 20'h0_0000;
				end else begin
					sel_cfg_ff <= word;
					ua_ff      <= nxt_ua;
					mult_ff    <= nxt_mult;
				end
			end

			assign pll_pre_scale[g*8+:8]        = sel_cfg_ff[pin_mux_pkg::PRE_LSB+:8];
			assign pll_feedback_count[g*12+:12] = sel_cfg_ff[N_L+:12];
			assign pll_additive_count[g*4+:4]   = sel_cfg_ff[A_L+:4];
			assign pll_total_mult_x64[g*20+:20] = mult_ff;
			assign filter_resistor_code[g*4+:4] = sel_cfg_ff[pin_mux_pkg::RES_LSB+:4];
			assign filter_cap_code_a[g*4+:4]    = sel_cfg_ff[pin_mux_pkg::CAPA_LSB+:4];
			assign filter_cap_code_b[g*4+:4]    = sel_cfg_ff[pin_mux_pkg::CAPB_LSB+:4];
			assign pump_current_code[g*3+:3]    = sel_cfg_ff[I_L+:3];
			assign pump_current_ua[g*10+:10]    = ua_ff;
			assign post_div_select[g]           = sel_cfg_ff[pin_mux_pkg::ODIV_LSB];
		end
	endgenerate

endmodule : multipurpose_pin_mode_mux

`default_nettype wire

// [testbench/pin_mux_chk.sv]
`timescale 1ns/100ps
`default_nettype none

// ========================================
// mode decode, pin routing and pump current checks
module pin_mux_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// mode and pins
	input wire logic        manual_freq_ctrl_bit,
	input wire logic        iface_sel_high,
	input wire logic        iface_sel_low,
	input wire logic        gen_input_zero,
	input wire logic        gen_input_one,
	input wire logic        gen_input_two,
	input wire logic        gen_input_three,
	input wire logic        pll_lock_lost,
	input wire logic        ref_clock_lost,
	// outputs
	input wire logic        gen_output_zero,
	input wire logic        gen_output_one,
	input wire logic [1:0]  mode_out,
	input wire logic        serial_data_to_engine,
	input wire logic        serial_clock_to_engine,
	input wire logic        suspend_outputs,
	input wire logic [1:0]  pll1_cfg_sel,
	input wire logic [8:0]  pump_current_code,
	input wire logic [29:0] pump_current_ua
);
	// not all-pll: lets gating lead or lag the mode flop by a cycle
	logic not_all;
	assign not_all = iface_sel_high || iface_sel_low || manual_freq_ctrl_bit;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_serial; iface_sel_high[*5] |-> mode_out == 2'h2; endproperty
	a_serial: assert property (p_serial) else $error("serial mode missed");
	property p_scan; (iface_sel_low && !iface_sel_high)[*5] |-> mode_out == 2'h3; endproperty
	a_scan: assert property (p_scan) else $error("scan mode missed");
	property p_single;
		(!iface_sel_high && !iface_sel_low && manual_freq_ctrl_bit)[*5] |-> mode_out == 2'h0;
	endproperty
	a_single: assert property (p_single) else $error("single mode missed");
	property p_sdata; (mode_out == 2'h2 && gen_input_zero)[*4] |-> serial_data_to_engine; endproperty
	a_sdata: assert property (p_sdata) else $error("bus data not routed");
	property p_sclk; (mode_out == 2'h2 && gen_input_one)[*4] |-> serial_clock_to_engine; endproperty
	a_sclk: assert property (p_sclk) else $error("bus clock not routed");
	property p_gate;
		(!iface_sel_high)[*5] |-> !serial_data_to_engine && !serial_clock_to_engine;
	endproperty
	a_gate: assert property (p_gate) else $error("bus pins leak");
	property p_susp;
		(mode_out != 2'h1 && not_all && $stable(gen_input_three))[*5]
			|-> suspend_outputs == gen_input_three;
	endproperty
	a_susp: assert property (p_susp) else $error("suspend wrong");
	property p_sel1;
		(mode_out == 2'h1 && !not_all && $stable({gen_input_three, gen_input_two}))[*5]
			|-> pll1_cfg_sel == {gen_input_three, gen_input_two};
	endproperty
	a_sel1: assert property (p_sel1) else $error("pll1 select wrong");
	property p_lock;
		(mode_out != 2'h3 && !iface_sel_low && $stable(pll_lock_lost))[*5]
			|-> gen_output_zero == pll_lock_lost;
	endproperty
	a_lock: assert property (p_lock) else $error("lock loss flag wrong");
	property p_refl; $stable(ref_clock_lost)[*5] |-> gen_output_one == ref_clock_lost; endproperty
	a_refl: assert property (p_refl) else $error("ref loss flag wrong");
	property p_pump;
		$stable(pump_current_code[2:0])[*3]
			|-> pump_current_ua[9:0] == (10'h005 << pump_current_code[2:0]);
	endproperty
	a_pump: assert property (p_pump) else $error("pump current wrong");
endmodule : pin_mux_chk

bind multipurpose_pin_mode_mux pin_mux_chk i_pin_mux_chk (
	.clock, .rst_n, .manual_freq_ctrl_bit, .iface_sel_high, .iface_sel_low,
	.gen_input_zero, .gen_input_one, .gen_input_two, .gen_input_three,
	.pll_lock_lost, .ref_clock_lost, .gen_output_zero, .gen_output_one, .mode_out,
	.serial_data_to_engine, .serial_clock_to_engine, .suspend_outputs,
	.pll1_cfg_sel, .pump_current_code, .pump_current_ua
);

`default_nettype wire

// [testbench/scan_tester.sv]
`timescale 1ns/100ps
`default_nettype none

// ========================================
// boundary-scan tester on the far side
module scan_tester (
	// scan pins toward the device
	output var logic tck,
	output var logic tdi,
	output var logic tms,
	output var logic trst_n
);
	initial begin
		tck    = 1'b0;
		tdi    = 1'b0;
		tms    = 1'b0;
		trst_n = 1'b1;
	end

	// change after the falling edge, device samples on the rising one
	task automatic step(input logic m, input logic d);
		tms = m;
		tdi = d;
		#3 tck = 1'b1;
		#3 tck = 1'b0;
	endtask : step

	// clock stands still between frames
	task automatic send(input logic [50:0] w);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		for (int i = 0; i < 51; i++) step(i == 50, w[i]);
		step(1'b0, 1'b0);
		tdi = ~tdi; // released data line never shows a stale level
	endtask : send
endmodule : scan_tester

`default_nettype wire

// [testbench/multipurpose_pin_mode_mux_tb.sv]
`timescale 1ns/100ps
`default_nettype none

// ========================================
// bench top
module multipurpose_pin_mode_mux_tb;
	logic        clock, rst_n, manual_freq_ctrl_bit, iface_sel_high, iface_sel_low;
	logic        pll_lock_lost, ref_clock_lost, cfg_wr_en, use_scan, tck, tdi, tms, trst_n;
	logic [1:0]  cfg_wr_pll, cfg_wr_slot, mode_out, pll1_cfg_sel, pll2_cfg_sel;
	logic [2:0]  pll0_cfg_sel, post_div_select;
	logic [5:0]  pin;
	logic [46:0] cfg_wr_data;
	logic        gen_input_zero, gen_input_one, gen_input_two, gen_input_three;
	logic        gen_input_four, gen_input_five, gen_output_zero, gen_output_one;
	logic        serial_mode_active, serial_data_to_engine, serial_clock_to_engine;
	logic        suspend_outputs, ref_select_secondary;
	logic [23:0] pll_pre_scale;
	logic [35:0] pll_feedback_count;
	logic [11:0] pll_additive_count, filter_resistor_code, filter_cap_code_a, filter_cap_code_b;
	logic [59:0] pll_total_mult_x64;
	logic [8:0]  pump_current_code;
	logic [29:0] pump_current_ua;
	int          err_total, checks;

	// scan tester owns pins zero, one, two and four in scan mode
	assign gen_input_zero  = use_scan ? tdi : pin[0];
	assign gen_input_one   = use_scan ? tck : pin[1];
	assign gen_input_two   = use_scan ? tms : pin[2];
	assign gen_input_four  = use_scan ? trst_n : pin[4];
	assign gen_input_three = pin[3];
	assign gen_input_five  = pin[5];

	multipurpose_pin_mode_mux i_multipurpose_pin_mode_mux (
		.clock, .rst_n, .link_clock(tck), .manual_freq_ctrl_bit, .iface_sel_high,
		.iface_sel_low, .gen_input_zero, .gen_input_one, .gen_input_two, .gen_input_three,
		.gen_input_four, .gen_input_five, .pll_lock_lost, .ref_clock_lost, .cfg_wr_en,
		.cfg_wr_pll, .cfg_wr_slot, .cfg_wr_data, .gen_output_zero, .gen_output_one,
		.mode_out, .serial_mode_active, .serial_data_to_engine, .serial_clock_to_engine,
		.suspend_outputs, .ref_select_secondary, .pll0_cfg_sel, .pll1_cfg_sel,
		.pll2_cfg_sel, .pll_pre_scale, .pll_feedback_count, .pll_additive_count,
		.pll_total_mult_x64, .filter_resistor_code, .filter_cap_code_a,
		.filter_cap_code_b, .pump_current_code, .pump_current_ua, .post_div_select
	);
	scan_tester i_scan_tester (.tck, .tdi, .tms, .trst_n);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ========================================
	// helpers
	// slot word k: additive count above two
	// nonzero offset whenever the fraction is on
	// top bit is only the post-divider choice, never a disable
	function automatic logic [46:0] word(input logic [3:0] k);
		return {k[0], k[2:0], 4'hF - k, k + 4'h1, k, k[0], 6'h30, 4'h3,
			12'h00F + {8'h00, k}, 8'h10 + {4'h0, k}};
	endfunction : word

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic settle;
		repeat (6) @(posedge clock);
		#1;
	endtask : settle

	task automatic chk_pll(input int p, input logic [3:0] k);
		chk("prescale", 8'h10 + k, pll_pre_scale[p*8 +: 8]);
		chk("feedback", 12'h00F + k, pll_feedback_count[p*12 +: 12]);
		chk("additive", 4'h3, pll_additive_count[p*4 +: 4]);
		chk("pump code", k[2:0], pump_current_code[p*3 +: 3]);
		chk("mult", (34 + 2 * k) * 64 + (k[0] ? 48 : 0), pll_total_mult_x64[p*20 +: 20]);
		chk("resistor", k, filter_resistor_code[p*4 +: 4]);
		chk("cap a", k + 4'h1, filter_cap_code_a[p*4 +: 4]);
		chk("cap b", 4'hF - k, filter_cap_code_b[p*4 +: 4]);
		chk("pump", 10'h005 << k[2:0], pump_current_ua[p*10 +: 10]);
		chk("postdiv", k[0], post_div_select[p]);
	endtask : chk_pll

	// ========================================
	// scenarios
	task automatic serial_load;
		@(posedge clock);
		iface_sel_high <= 1'b1;
		pin            <= 6'h03;
		settle;
		chk("mode", 2'h2, mode_out);
		chk("bus data", 1'b1, serial_data_to_engine);
		chk("bus clock", 1'b1, serial_clock_to_engine);
		chk("serial active", 1'b1, serial_mode_active);
		for (int s = 0; s < 9; s++) begin
			@(posedge clock);
			cfg_wr_en   <= 1'b1;
			cfg_wr_pll  <= (s == 8) ? 2'h3 : (s < 4) ? 2'h0 : (s < 6) ? 2'h1 : 2'h2;
			cfg_wr_slot <= (s < 4 || s == 8) ? s[1:0] : {1'b1, s[0]};
			cfg_wr_data <= word(s[3:0]);
		end
		@(posedge clock);
		cfg_wr_en <= 1'b0;
	endtask : serial_load

	task automatic single_sweep;
		@(posedge clock);
		iface_sel_high       <= 1'b0;
		manual_freq_ctrl_bit <= 1'b1;
		pin                  <= 6'h2B;
		settle;
		chk("mode", 2'h0, mode_out);
		chk("suspend", 1'b1, suspend_outputs);
		chk("ref select", 1'b1, ref_select_secondary);
		chk("bus gated", 1'b0, serial_data_to_engine);
		chk("serial active", 1'b0, serial_mode_active);
		@(posedge clock);
		cfg_wr_en   <= 1'b1;
		cfg_wr_pll  <= 2'h0;
		cfg_wr_slot <= 2'h0;
		cfg_wr_data <= word(4'h9);
		@(posedge clock);
		cfg_wr_en <= 1'b0;
		for (int s = 0; s < 8; s++) begin
			@(posedge clock);
			pin <= {3'b101, s[2:0]};
			settle;
			chk("sel0", s[2:0], pll0_cfg_sel);
			chk_pll(0, s[3:0]);
		end
	endtask : single_sweep

	task automatic all_pll;
		@(posedge clock);
		manual_freq_ctrl_bit <= 1'b0;
		pin                  <= 6'h39;
		settle;
		chk("mode", 2'h1, mode_out);
		chk("sel1", 2'h2, pll1_cfg_sel);
		chk("sel2", 2'h3, pll2_cfg_sel);
		chk("suspend", 1'b0, suspend_outputs);
		chk_pll(0, 4'h1);
		chk_pll(1, 4'h4);
		chk_pll(2, 4'h7);
	endtask : all_pll

	task automatic status_flags;
		for (int v = 0; v < 2; v++) begin
			@(posedge clock);
			pll_lock_lost  <= v[0];
			ref_clock_lost <= !v[0];
			settle;
			chk("lock lost", v[0], gen_output_zero);
			chk("ref lost", !v[0], gen_output_one);
		end
	endtask : status_flags

	task automatic scan_write;
		@(posedge clock);
		iface_sel_low <= 1'b1;
		settle;
		chk("mode", 2'h3, mode_out);
		chk("scan data out", 1'b0, gen_output_zero);
		@(posedge clock);
		use_scan <= 1'b1;
		#1;
		i_scan_tester.send({2'h1, 2'h0, word(4'hA)});
		settle;
		chk("sel0 held", 3'h1, pll0_cfg_sel);
		chk_pll(0, 4'hA);
	endtask : scan_write

	task automatic tally_and_finish;
		if (err_total == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		err_total            = 0;
		checks               = 0;
		rst_n                = 1'b0;
		manual_freq_ctrl_bit = 1'b0;
		iface_sel_high       = 1'b0;
		iface_sel_low        = 1'b0;
		pin                  = 6'h00;
		pll_lock_lost        = 1'b0;
		ref_clock_lost       = 1'b0;
		cfg_wr_en            = 1'b0;
		cfg_wr_pll           = 2'h0;
		cfg_wr_slot          = 2'h0;
		cfg_wr_data          = 47'h0000_0000_0000;
		use_scan             = 1'b0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		serial_load;
		single_sweep;
		all_pll;
		status_flags;
		scan_write;
		tally_and_finish;
	end

	// hang guard, far above the run of about 140 clock cycles
	initial begin
		#500000;
		err_total++;
		tally_and_finish;
	end
endmodule : multipurpose_pin_mode_mux_tb

`default_nettype wire
